/* File: rtl/iss_spi_regs.sv */
`timescale 1ns/10ps
module iss_spi_regs
(
  // Clock, reset, enable
  input  wire logic        I_MCLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_CLK_EN,
  // Serial pins
  input  wire logic        I_SCLK,
  input  wire logic        I_CHIP_SELECT_N,
  input  wire logic        I_SDI,
  output logic             O_SDO,
  output logic             O_SDO_OE,
  // Interrupt pin
  output logic             O_INTERRUPT_PIN_N,
  // Measurement front end
  input  wire logic        I_NEW_RESULT,
  input  wire logic [7:0]  I_PROXIMITY,
  input  wire logic [23:0] I_FREQ_COUNT,
  input  wire logic        I_OSCILLATOR_STOPPED,
  // Decoded configuration
  output logic             O_CONVERSION_ENABLE,
  output logic [7:0]       O_UPPER_IMPEDANCE_CODE,
  output logic [7:0]       O_LOWER_IMPEDANCE_CODE,
  output logic [7:0]       O_WATCHDOG_FREQ,
  output logic [1:0]       O_AMPLITUDE,
  output logic [2:0]       O_RESPONSE_TIME,
  output logic [2:0]       O_PIN_EVENT_SELECT
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Third serial clock stage only feeds the edge detector, never the logic
  logic [2:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] sdi_s_r;
  logic       cs_q_r;

  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sclk_s_r <= 3'b000;
      cs_s_r   <= 2'b11;
      sdi_s_r  <= 2'b00;
      cs_q_r   <= 1'b1;
    end
    else if (I_CLK_EN)
    begin
      sclk_s_r <= {sclk_s_r[1:0], I_SCLK};
      cs_s_r   <= {cs_s_r[0], I_CHIP_SELECT_N};
      sdi_s_r  <= {sdi_s_r[0], I_SDI};
      cs_q_r   <= cs_s_r[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_n;
  logic cs_start;
  logic sdi;

  assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
  assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
  assign cs_n      = cs_s_r[1];
  assign cs_start  = cs_q_r & ~cs_s_r[1];
  assign sdi       = sdi_s_r[1];

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0]  upper_r;
  logic [7:0]  lower_r;
  logic [7:0]  wdog_r;
  logic [7:0]  config_r;
  logic [7:0]  rsvb_r;
  logic [7:0]  thhi_r;
  logic [7:0]  rsvc_r;
  logic [7:0]  thlo_r;
  logic [7:0]  pincfg_r;
  logic [7:0]  power_r;
  logic [7:0]  prox_r;
  logic [23:0] fcount_r;
  logic        cmp_r;
  logic        wake_r;
  logic        rdy_n_r;

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  iss_pkg::iss_state_t state_r;
  logic [2:0]          bit_cnt_r;
  logic [7:0]          shift_in_r;
  logic [6:0]          addr_r;
  logic                read_r;
  logic [7:0]          shift_out_r;
  logic                sdo_oe_r;
  logic                write_strobe;
  logic                prox_read_start;
  logic [7:0]          wr_data;
  logic [6:0]          cmd_addr;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign wr_data  = {shift_in_r[6:0], sdi};
  assign cmd_addr = {shift_in_r[5:0], sdi};
  // Commit on the eighth bit of each data byte; 16th clock for the first
  assign write_strobe = (state_r == iss_pkg::ISS_DATA) && sclk_rise && !cs_n
                        && (bit_cnt_r == iss_pkg::CMD_LAST) && !read_r;
  assign prox_read_start = (state_r == iss_pkg::ISS_CMD) && sclk_rise && !cs_n
                           && (bit_cnt_r == iss_pkg::CMD_LAST) && shift_in_r[6]
                           && (cmd_addr == iss_pkg::ADDR_PROX);

  function automatic logic [7:0] read_mux(input logic [6:0] a);
    case (a)
      iss_pkg::ADDR_ID:     read_mux = iss_pkg::ID_VALUE;
      iss_pkg::ADDR_UPPER:  read_mux = upper_r;
      iss_pkg::ADDR_LOWER:  read_mux = lower_r;
      iss_pkg::ADDR_WDOG:   read_mux = wdog_r;
      iss_pkg::ADDR_CONFIG: read_mux = config_r;
      iss_pkg::ADDR_RSVA:   read_mux = iss_pkg::RST_RSVA;
      iss_pkg::ADDR_RSVB:   read_mux = rsvb_r;
      iss_pkg::ADDR_THHI:   read_mux = thhi_r;
      iss_pkg::ADDR_RSVC:   read_mux = rsvc_r;
      iss_pkg::ADDR_THLO:   read_mux = thlo_r;
      iss_pkg::ADDR_PINCFG: read_mux = pincfg_r;
      iss_pkg::ADDR_POWER:  read_mux = power_r;
      iss_pkg::ADDR_STATUS: read_mux = {I_OSCILLATOR_STOPPED, rdy_n_r, wake_r, cmp_r, 4'h0};
      iss_pkg::ADDR_PROX:   read_mux = prox_r;
      iss_pkg::ADDR_FCLO:   read_mux = fcount_r[7:0];
      iss_pkg::ADDR_FCMID:  read_mux = fcount_r[15:8];
      iss_pkg::ADDR_FCHI:   read_mux = fcount_r[23:16];
      default:              read_mux = 8'h00;
    endcase
  endfunction

  // Threshold compare shared by comparator and wake-up flags
  function automatic logic over_high(input logic [7:0] p, input logic [7:0] t);
    over_high = (p > t);
  endfunction

  // Idle moves to command one cycle after select, well before the first clock edge
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_r    <= iss_pkg::ISS_IDLE;
      bit_cnt_r  <= 3'd0;
      shift_in_r <= 8'h00;
      addr_r     <= 7'h00;
      read_r     <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (cs_n)
      begin
        // Deselect abandons any partial byte, so no write lands
        state_r   <= iss_pkg::ISS_IDLE;
        bit_cnt_r <= 3'd0;
      end
      else if (cs_start || state_r == iss_pkg::ISS_IDLE)
      begin
        state_r   <= iss_pkg::ISS_CMD;
        bit_cnt_r <= 3'd0;
      end
      else if (sclk_rise)
      begin
        shift_in_r <= wr_data;
        bit_cnt_r  <= bit_cnt_r + 3'd1;
        if (bit_cnt_r == iss_pkg::CMD_LAST)
        begin
          if (state_r == iss_pkg::ISS_CMD)
          begin
            read_r  <= shift_in_r[6];
            addr_r  <= cmd_addr;
            state_r <= iss_pkg::ISS_DATA;
          end
          else
            addr_r <= addr_r + 7'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read data path
  // ------------------------------------------------------------
  // Output byte loads right after each command or data byte completes
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      shift_out_r <= 8'h00;
      sdo_oe_r    <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (cs_n)
        sdo_oe_r <= 1'b0;
      else if (state_r == iss_pkg::ISS_DATA && read_r && sclk_fall)
      begin
        sdo_oe_r <= 1'b1;
        if (bit_cnt_r == 3'd0)
          shift_out_r <= read_mux(addr_r);
        else
          shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  assign O_SDO    = shift_out_r[7];
  assign O_SDO_OE = sdo_oe_r;

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  // Lock follows the stored power bit, so the write that wakes the part is not itself blocked
  logic locked;
  assign locked = power_r[iss_pkg::PWR_BIT] && (addr_r >= iss_pkg::ADDR_UPPER)
                  && (addr_r <= iss_pkg::ADDR_RSVA);

  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      upper_r  <= iss_pkg::RST_UPPER;
      lower_r  <= iss_pkg::RST_LOWER;
      wdog_r   <= iss_pkg::RST_WDOG;
      config_r <= iss_pkg::RST_CONFIG;
      rsvb_r   <= iss_pkg::RST_RSVB;
      thhi_r   <= iss_pkg::RST_THHI;
      rsvc_r   <= iss_pkg::RST_RSVC;
      thlo_r   <= iss_pkg::RST_THLO;
      pincfg_r <= iss_pkg::RST_PINCFG;
      power_r  <= iss_pkg::RST_POWER;
    end
    else if (I_CLK_EN && write_strobe && !locked)
    begin
      // Reserved 0x05 has no storage; it always reads its fixed value
      case (addr_r)
        iss_pkg::ADDR_UPPER:  upper_r  <= wr_data;
        iss_pkg::ADDR_LOWER:  lower_r  <= wr_data;
        iss_pkg::ADDR_WDOG:   wdog_r   <= wr_data;
        iss_pkg::ADDR_CONFIG: config_r <= wr_data;
        iss_pkg::ADDR_RSVB:   rsvb_r   <= wr_data;
        iss_pkg::ADDR_THHI:   thhi_r   <= wr_data;
        iss_pkg::ADDR_RSVC:   rsvc_r   <= wr_data;
        iss_pkg::ADDR_THLO:   thlo_r   <= wr_data;
        iss_pkg::ADDR_PINCFG: pincfg_r <= wr_data;
        iss_pkg::ADDR_POWER:  power_r  <= wr_data;
        default:              upper_r  <= upper_r;
      endcase
    end
  end

  assign O_CONVERSION_ENABLE    = power_r[iss_pkg::PWR_BIT];
  assign O_UPPER_IMPEDANCE_CODE = upper_r;
  assign O_LOWER_IMPEDANCE_CODE = lower_r;
  assign O_WATCHDOG_FREQ        = wdog_r;
  assign O_AMPLITUDE            = config_r[iss_pkg::CFG_AMP_LSB +: 2];
  assign O_RESPONSE_TIME        = config_r[iss_pkg::CFG_RSP_LSB +: 3];
  assign O_PIN_EVENT_SELECT     = pincfg_r[2:0];

  // ------------------------------------------------------------
  // Results, status and interrupt pin
  // ------------------------------------------------------------
  logic [7:0]  prox_live_r;
  logic [23:0] fcount_live_r;
  logic        pin_r;

  // Live copy follows every conversion
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      prox_live_r   <= 8'h00;
      fcount_live_r <= 24'h00_0000;
    end
    else if (I_CLK_EN && I_NEW_RESULT)
    begin
      prox_live_r   <= I_PROXIMITY;
      fcount_live_r <= I_FREQ_COUNT;
    end
  end

  // Host copy only moves when a proximity read begins, so a slow burst never mixes two conversions
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      prox_r   <= 8'h00;
      fcount_r <= 24'h00_0000;
    end
    else if (I_CLK_EN && prox_read_start)
    begin
      prox_r   <= prox_live_r;
      fcount_r <= fcount_live_r;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      cmp_r <= 1'b1;
    else if (I_CLK_EN)
    begin
      if (over_high(prox_live_r, thhi_r))
        cmp_r <= 1'b0;
      else if (prox_live_r < thlo_r)
        cmp_r <= 1'b1;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      wake_r <= 1'b1;
    else if (I_CLK_EN)
    begin
      if (pincfg_r[2:0] != iss_pkg::PIN_WAKE)
        wake_r <= 1'b1;
      else if (over_high(prox_live_r, thhi_r))
        wake_r <= 1'b0;
    end
  end

  // A new result wins over a simultaneous read
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      rdy_n_r <= 1'b1;
    else if (I_CLK_EN)
    begin
      if (I_NEW_RESULT)
        rdy_n_r <= 1'b0;
      else if (prox_read_start)
        rdy_n_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  // Registered so the pin never glitches while the mode field is rewritten
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      pin_r <= 1'b1;
    else if (I_CLK_EN)
    begin
      case (pincfg_r[2:0])
        iss_pkg::PIN_WAKE: pin_r <= wake_r;
        iss_pkg::PIN_CMP:  pin_r <= cmp_r;
        iss_pkg::PIN_RDY:  pin_r <= rdy_n_r;
        default:           pin_r <= 1'b1;
      endcase
    end
  end

  assign O_INTERRUPT_PIN_N = pin_r;

endmodule

/* File: rtl/iss_pkg.sv */
// Functional notes
// - Transfer opens with an 8-bit command: direction bit then 7-bit address, then data.
// - Direction bit zero means write, one means read.
// - Every chip select assertion restarts command decoding from the first bit.
// - Output bits launch on falling clock edges, input bits captured on rising edges.
// - Write data commits on the rising edge of the sixteenth clock.
// - Chip select released before the sixteenth clock discards the partial write.
// - Beyond sixteen clocks the address advances by one per further byte.
// - Burst reads shift and burst writes store one register every eight clocks.
// - While converting, registers 0x01 to 0x05 ignore writes.
// - Upper impedance code accepts 0x00 to 0x1F, resets to 0x0E.
// - Config bits 4:3 select amplitude, bits 2:0 select response time.
// - Pin mode 000 off, 001 wake-up, 010 comparator, 100 data-ready.
// - Power bit 0 selects standby or active conversion; resets to standby.
// - Status bit 7 is oscillator stopped, bit 6 is active-low result ready.
// - Status bit 5 low on wake-up trigger; bit 4 comparator state.
// - 24-bit count sits low byte first at 0x23 through 0x25.
// - Count registers latch new data only when a read of 0x22 starts.
// - Burst read from 0x22 returns proximity then three count bytes.
// - Comparator mode: pin asserts above high, deasserts below low threshold.
// - Wake-up mode: pin asserts above high, holds until wake-up disabled.
// - Data-ready mode: pin asserts on new result, clears on read of 0x22.
package iss_pkg;
  localparam logic [6:0] ADDR_ID     = 7'h00;
  localparam logic [6:0] ADDR_UPPER  = 7'h01;
  localparam logic [6:0] ADDR_LOWER  = 7'h02;
  localparam logic [6:0] ADDR_WDOG   = 7'h03;
  localparam logic [6:0] ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ADDR_RSVA   = 7'h05;
  localparam logic [6:0] ADDR_RSVB   = 7'h06;
  localparam logic [6:0] ADDR_THHI   = 7'h07;
  localparam logic [6:0] ADDR_RSVC   = 7'h08;
  localparam logic [6:0] ADDR_THLO   = 7'h09;
  localparam logic [6:0] ADDR_PINCFG = 7'h0A;
  localparam logic [6:0] ADDR_POWER  = 7'h0B;
  localparam logic [6:0] ADDR_STATUS = 7'h20;
  localparam logic [6:0] ADDR_RSVD   = 7'h21;
  localparam logic [6:0] ADDR_PROX   = 7'h22;
  localparam logic [6:0] ADDR_FCLO   = 7'h23;
  localparam logic [6:0] ADDR_FCMID  = 7'h24;
  localparam logic [6:0] ADDR_FCHI   = 7'h25;
  // Arbitrary identification value
  localparam logic [7:0] ID_VALUE    = 8'h5A;
  localparam logic [7:0] RST_UPPER   = 8'h0E;
  localparam logic [7:0] RST_LOWER   = 8'h14;
  localparam logic [7:0] RST_WDOG    = 8'h45;
  localparam logic [7:0] RST_CONFIG  = 8'h1B;
  localparam logic [7:0] RST_RSVA    = 8'h01;
  localparam logic [7:0] RST_RSVB    = 8'hFF;
  localparam logic [7:0] RST_THHI    = 8'hFF;
  localparam logic [7:0] RST_RSVC    = 8'h00;
  localparam logic [7:0] RST_THLO    = 8'h00;
  localparam logic [7:0] RST_PINCFG  = 8'h00;
  localparam logic [7:0] RST_POWER   = 8'h00;
  localparam int         CFG_AMP_LSB = 3;
  localparam int         CFG_RSP_LSB = 0;
  localparam int         PWR_BIT     = 0;
  localparam int         ST_OSC      = 7;
  localparam int         ST_RDY      = 6;
  localparam int         ST_WAKE     = 5;
  localparam int         ST_CMP      = 4;
  localparam logic [2:0] PIN_OFF     = 3'b000;
  localparam logic [2:0] PIN_WAKE    = 3'b001;
  localparam logic [2:0] PIN_CMP     = 3'b010;
  localparam logic [2:0] PIN_RDY     = 3'b100;
  localparam logic [2:0] CMD_LAST    = 3'h7;
  typedef enum logic [1:0]
  {
    ISS_IDLE = 2'b00,
    ISS_CMD  = 2'b01,
    ISS_DATA = 2'b11
  } iss_state_t;
endpackage

/* File: verif/iss_spi_regs_assertions.sv */
`timescale 1ns/10ps
module iss_spi_regs_assertions
(
  // Clock and reset
  input wire logic       I_MCLK,
  input wire logic       I_SYS_RST,
  // Serial pins
  input wire logic       I_SCLK,
  input wire logic       I_CHIP_SELECT_N,
  input wire logic       O_SDO,
  input wire logic       O_SDO_OE,
  // Pin and settings
  input wire logic       O_INTERRUPT_PIN_N,
  input wire logic       I_NEW_RESULT,
  input wire logic       O_CONVERSION_ENABLE,
  input wire logic [7:0] O_UPPER_IMPEDANCE_CODE,
  input wire logic [1:0] O_AMPLITUDE,
  input wire logic [2:0] O_RESPONSE_TIME,
  input wire logic [2:0] O_PIN_EVENT_SELECT
);
  logic [7:0]  edges_r;
  logic        sclk_r;
  logic [12:0] cfg;
  assign cfg = {O_UPPER_IMPEDANCE_CODE, O_AMPLITUDE, O_RESPONSE_TIME};
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  // Raw serial clock rises seen within the frame; the design lags these by its synchroniser
  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      edges_r <= 8'h00;
      sclk_r  <= 1'b0;
    end
    else
    begin
      sclk_r <= I_SCLK;
      if (I_CHIP_SELECT_N)
        edges_r <= 8'h00;
      else if (I_SCLK && !sclk_r)
        edges_r <= edges_r + 8'h01;
    end
  end
  a_oe_off_deselected: assert property (I_CHIP_SELECT_N [*6] |-> !O_SDO_OE)
    else $error("output driven while deselected");
  a_sdo_hold_rise: assert property (O_SDO_OE && $rose(I_SCLK) |=> $stable(O_SDO) [*3])
    else $error("output moved after rising clock");
  a_oe_after_command: assert property ($rose(O_SDO_OE) |-> edges_r == 8'h08)
    else $error("output enabled off the command end");
  a_commit_byte_edge: assert property (!$stable({O_CONVERSION_ENABLE, cfg, O_PIN_EVENT_SELECT})
    |-> edges_r >= 8'h10 && edges_r[2:0] == 3'h0)
    else $error("setting changed off a byte end");
  a_lock_while_active: assert property (O_CONVERSION_ENABLE && $past(O_CONVERSION_ENABLE) |-> $stable(cfg))
    else $error("locked setting changed");
  a_pin_off_idle: assert property ((O_PIN_EVENT_SELECT == iss_pkg::PIN_OFF) [*3] |-> O_INTERRUPT_PIN_N)
    else $error("pin asserted while disabled");
  a_wake_pin_holds: assert property (O_PIN_EVENT_SELECT == iss_pkg::PIN_WAKE
    && $past(O_PIN_EVENT_SELECT) == iss_pkg::PIN_WAKE && !$past(O_INTERRUPT_PIN_N) |-> !O_INTERRUPT_PIN_N)
    else $error("wake pin released early");
  a_ready_pin_new: assert property (I_NEW_RESULT && O_PIN_EVENT_SELECT == iss_pkg::PIN_RDY
    |-> ##[1:3] !O_INTERRUPT_PIN_N)
    else $error("ready pin missed a result");
  cover property ($rose(O_SDO_OE));
  cover property ($fell(O_INTERRUPT_PIN_N));
  cover property ($rose(O_CONVERSION_ENABLE));
endmodule
bind iss_spi_regs iss_spi_regs_assertions iss_spi_regs_assertions_inst
(
  .I_MCLK                 (I_MCLK),
  .I_SYS_RST              (I_SYS_RST),
  .I_SCLK                 (I_SCLK),
  .I_CHIP_SELECT_N        (I_CHIP_SELECT_N),
  .O_SDO                  (O_SDO),
  .O_SDO_OE               (O_SDO_OE),
  .O_INTERRUPT_PIN_N      (O_INTERRUPT_PIN_N),
  .I_NEW_RESULT           (I_NEW_RESULT),
  .O_CONVERSION_ENABLE    (O_CONVERSION_ENABLE),
  .O_UPPER_IMPEDANCE_CODE (O_UPPER_IMPEDANCE_CODE),
  .O_AMPLITUDE            (O_AMPLITUDE),
  .O_RESPONSE_TIME        (O_RESPONSE_TIME),
  .O_PIN_EVENT_SELECT     (O_PIN_EVENT_SELECT)
);

/* File: verif/iss_host_model.sv */
`timescale 1ns/10ps
module iss_host_model
(
  // Serial pins
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // Command then n data bits, MSB first; clock stands low outside frames
  task automatic frame(input logic [7:0] cmd, input int n, input logic [95:0] wd, output logic [95:0] rd);
    logic [103:0] sh;
    sh = {cmd, wd};
    rd = '0;
    #13 o_cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++)
    begin
      o_sdi = sh[103-i];
      #160 o_sclk = 1'b1;
      if (i > 7)
        rd[103-i] = i_sdo_oe ? i_sdo : 1'bx;
      #160 o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    // Released line flips so a stale level is never read as data
    o_sdi = ~o_sdi;
    #200;
  endtask
endmodule

/* File: verif/iss_spi_regs_tb.sv */
`timescale 1ns/10ps
module iss_spi_regs_tb;
  logic        mclk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        oe;
  logic        pin_n;
  logic        nres;
  logic [7:0]  prox;
  logic [23:0] fc;
  logic        osc;
  logic        pwr;
  logic [7:0]  up;
  logic [7:0]  lo;
  logic [7:0]  wdg;
  logic [1:0]  amp;
  logic [2:0]  rsp;
  logic [2:0]  psel;
  logic [95:0] rd;
  logic [95:0] wd;
  logic [31:0] res;
  logic [31:0] r;
  int          errors;
  int          checks;
  int          seed;
  localparam logic [95:0] DEFS = {iss_pkg::ID_VALUE, iss_pkg::RST_UPPER, iss_pkg::RST_LOWER, iss_pkg::RST_WDOG,
    iss_pkg::RST_CONFIG, iss_pkg::RST_RSVA, iss_pkg::RST_RSVB, iss_pkg::RST_THHI, iss_pkg::RST_RSVC,
    iss_pkg::RST_THLO, iss_pkg::RST_PINCFG, iss_pkg::RST_POWER};
  localparam logic [47:0] PSEQ = 48'hf050_1050_f010;
  localparam logic [5:0]  PEXP = 6'b001101;
  always #20 mclk = ~mclk;
  iss_spi_regs iss_spi_regs_inst
  (
    .I_MCLK (mclk), .I_SYS_RST (rst), .I_CLK_EN (1'b1), .I_SCLK (sclk), .I_CHIP_SELECT_N (cs_n),
    .I_SDI (sdi), .O_SDO (sdo), .O_SDO_OE (oe), .O_INTERRUPT_PIN_N (pin_n), .I_NEW_RESULT (nres),
    .I_PROXIMITY (prox), .I_FREQ_COUNT (fc), .I_OSCILLATOR_STOPPED (osc), .O_CONVERSION_ENABLE (pwr),
    .O_UPPER_IMPEDANCE_CODE (up), .O_LOWER_IMPEDANCE_CODE (lo), .O_WATCHDOG_FREQ (wdg),
    .O_AMPLITUDE (amp), .O_RESPONSE_TIME (rsp), .O_PIN_EVENT_SELECT (psel)
  );
  iss_host_model iss_host_model_inst
  (
    .i_sdo (sdo), .i_sdo_oe (oe), .o_sclk (sclk), .o_cs_n (cs_n), .o_sdi (sdi)
  );
  task automatic cmp_data(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Legal settings only: reserved bits at zero, codes inside their valid ranges
  function automatic logic [31:0] pick(input logic [31:0] v);
    logic [1:0] a;
    logic [2:0] t;
    a = (v[25:24] == 2'b11) ? 2'b10 : v[25:24];
    t = (v[30:28] < 3'h2) ? 3'h2 : v[30:28];
    return {3'h0, v[4:0], 3'h1, v[12:8], v[23:16], 3'h0, a, t};
  endfunction
  task automatic xfer(input logic dir, input logic [6:0] a, input int n, input logic [95:0] d);
    @(posedge mclk);
    #3;
    iss_host_model_inst.frame({dir, a}, n, d, rd);
  endtask
  task automatic result(input logic [7:0] p);
    @(posedge mclk);
    #3;
    r = $random(seed);
    prox = p;
    fc = r[23:0];
    nres = 1'b1;
    @(posedge mclk);
    #3;
    nres = 1'b0;
    res = {p, fc[7:0], fc[15:8], fc[23:16]};
    repeat (4) @(posedge mclk);
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    close_out;
  end
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    nres = 1'b0;
    prox = 8'h00;
    fc = 24'h00_0000;
    osc = 1'b0;
    errors = 0;
    checks = 0;
    seed = 32'haa70;
    repeat (16) @(posedge mclk);
    #3 rst = 1'b0;
    repeat (8) @(posedge mclk);
    cmp_data({pwr, up, lo, wdg, amp, rsp, psel}, {DEFS[0], DEFS[87:64], DEFS[60:56], DEFS[10:8]});
    xfer(1'b1, iss_pkg::ADDR_ID, 96, '0);
    cmp_data(rd, DEFS);
    $display("defaults done");
    for (int k = 0; k < 4; k++)
    begin
      r = (k == 0) ? 32'hffff_ffff : $random(seed);
      wd = {pick(r), 64'h0};
      xfer(1'b0, iss_pkg::ADDR_UPPER, 32, wd);
      cmp_data({up, lo, wdg, amp, rsp}, {wd[95:72], wd[68:64]});
      xfer(1'b1, iss_pkg::ADDR_UPPER, 32, '0);
      cmp_data(rd, wd);
    end
    xfer(1'b0, iss_pkg::ADDR_UPPER, 7, 96'h0);
    xfer(1'b0, iss_pkg::ADDR_WDOG, 15, {16'he412, 80'h0});
    wd[79:72] = 8'he4;
    cmp_data({up, lo, wdg, amp, rsp}, {wd[95:72], wd[68:64]});
    xfer(1'b0, iss_pkg::ADDR_ID, 8, '1);
    xfer(1'b0, 7'h30, 8, '1);
    xfer(1'b0, iss_pkg::ADDR_POWER, 8, {8'h01, 88'h0});
    cmp_data(pwr, 1'b1);
    xfer(1'b0, iss_pkg::ADDR_UPPER, 32, {32'h0020_0002, 64'h0});
    cmp_data({up, lo, wdg, amp, rsp}, {wd[95:72], wd[68:64]});
    xfer(1'b0, iss_pkg::ADDR_POWER, 8, '0);
    xfer(1'b1, iss_pkg::ADDR_ID, 8, '0);
    cmp_data(rd, {iss_pkg::ID_VALUE, 88'h0});
    xfer(1'b1, 7'h30, 8, '0);
    cmp_data(rd, '0);
    $display("writes done");
    osc = 1'b1;
    result(8'h40);
    xfer(1'b1, iss_pkg::ADDR_STATUS, 8, '0);
    cmp_data(rd[95:88], 8'hb0);
    xfer(1'b1, iss_pkg::ADDR_PROX, 32, '0);
    cmp_data(rd[95:64], res);
    wd[31:0] = res;
    osc = 1'b0;
    result(8'h50);
    xfer(1'b1, iss_pkg::ADDR_FCLO, 24, '0);
    cmp_data(rd[95:72], wd[23:0]);
    xfer(1'b1, iss_pkg::ADDR_STATUS, 8, '0);
    cmp_data(rd[95:88], 8'h30);
    $display("results done");
    xfer(1'b0, iss_pkg::ADDR_PINCFG, 8, {8'h04, 88'h0});
    cmp_pin(pin_n, 1'b0);
    xfer(1'b1, iss_pkg::ADDR_PROX, 32, '0);
    cmp_data(rd[95:64], res);
    cmp_pin(pin_n, 1'b1);
    result(8'h60);
    cmp_pin(pin_n, 1'b0);
    xfer(1'b0, iss_pkg::ADDR_THHI, 24, {24'h80_0020, 72'h0});
    xfer(1'b0, iss_pkg::ADDR_PINCFG, 8, {8'h02, 88'h0});
    for (int k = 0; k < 6; k++)
    begin
      result(PSEQ[47-8*k -: 8]);
      cmp_pin(pin_n, PEXP[5-k]);
    end
    xfer(1'b0, iss_pkg::ADDR_PINCFG, 8, {8'h01, 88'h0});
    result(8'hf0);
    cmp_pin(pin_n, 1'b0);
    result(8'h10);
    cmp_pin(pin_n, 1'b0);
    xfer(1'b1, iss_pkg::ADDR_STATUS, 8, '0);
    cmp_data(rd[95:88], 8'h10);
    xfer(1'b0, iss_pkg::ADDR_PINCFG, 8, '0);
    cmp_pin(pin_n, 1'b1);
    $display("pins done");
    close_out;
  end
endmodule
